// >>> rtl/contact_eval_pkg.sv
// shared types and constants of the boolean contact evaluator
package contact_eval_pkg;

   // ---------------------------------------------------------------
   // instruction set
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      op_rung_start,
      op_push_open_contact,
      op_push_closed_contact,
      op_push_word_bit,
      op_push_inverted_word_bit,
      op_parallel_open_contact,
      op_parallel_closed_contact,
      op_parallel_word_bit,
      op_parallel_inverted_word_bit,
      op_series_open_contact,
      op_series_closed_contact,
      op_series_word_bit,
      op_series_inverted_word_bit,
      op_merge_series_levels,
      op_merge_parallel_levels,
      op_coil_write,
      op_coil_word_bit,
      op_no_operation
   } opcode_type;

   typedef enum logic [2:0] {
      cls_input,
      cls_output,
      cls_stage,
      cls_control_relay,
      cls_system_flag_bit,
      cls_timer_done,
      cls_count_done_bit,
      cls_word_memory
   } point_class_type;

   typedef enum logic [2:0] {
      stk_hold,
      stk_clear,
      stk_push,
      stk_set_top,
      stk_merge_and,
      stk_merge_or
   } stack_op_type;

   // ---------------------------------------------------------------
   // operand limits (octal 0377, 0777, 0177 and bit 15)
   // ---------------------------------------------------------------
   localparam int unsigned   INDEX_DIGITS     = 4;
   localparam int unsigned   INDEX_W          = 3 * INDEX_DIGITS;
   localparam logic [11:0]   MAX_IO_INDEX     = 12'h0FF;
   localparam logic [11:0]   MAX_RELAY_INDEX  = 12'h1FF;
   localparam logic [11:0]   MAX_STATUS_INDEX = 12'h07F;
   localparam logic [3:0]    MAX_BCD_DIGIT    = 4'h9;
   localparam logic [3:0]    MAX_BIT_ONES_HI  = 4'h5;
   localparam logic [3:0]    BIT_TENS_WEIGHT  = 4'hA;
   localparam int unsigned   STACK_LEVELS     = 8;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      opcode_type               opcode;
      point_class_type          point_class;
      logic                     indirect;
      logic [4*INDEX_DIGITS-1:0] index_bcd;
      logic [7:0]               bit_bcd;
   } instr_type;

   typedef struct packed {
      point_class_type          point_class;
      logic                     indirect;
      logic [INDEX_W-1:0]       index;
      logic [3:0]               bit_num;
   } operand_ref_type;

endpackage : contact_eval_pkg

// >>> rtl/operand_decoder.sv
// operand decoder: octal point index, BCD bit number and range checks
`timescale 1ns/1ns
module operand_decoder
   import contact_eval_pkg::*;
(
   // raw instruction fields
   input  wire instr_type       instr,
   // decoded operand
   output operand_ref_type      oref,
   output logic                 index_ok,
   output logic                 bit_ok
);

   logic [INDEX_DIGITS-1:0] digit_ok;
   logic [INDEX_W-1:0]      index;
   logic [11:0]             limit;
   logic [3:0]              tens;
   logic [3:0]              ones;

   // ---------------------------------------------------------------
   // octal digits: a digit of 8 or 9 makes the index invalid
   // ---------------------------------------------------------------
   for (genvar i = 0; i < INDEX_DIGITS; i++) begin : g_digit
      assign digit_ok[i]        = ~instr.index_bcd[4*i+3];
      assign index[3*i +: 3]    = instr.index_bcd[4*i +: 3];
   end

   always_comb begin
      case (instr.point_class)
         cls_input, cls_output, cls_stage:        limit = MAX_IO_INDEX;
         cls_control_relay, cls_system_flag_bit:  limit = MAX_RELAY_INDEX;
         cls_timer_done, cls_count_done_bit:      limit = MAX_STATUS_INDEX;
         default:                                 limit = {INDEX_W{1'b1}};
      endcase
   end

   assign index_ok = (&digit_ok) && (index <= limit);

   // ---------------------------------------------------------------
   // bit number: two BCD digits, 0 to 15
   // ---------------------------------------------------------------
   assign tens   = instr.bit_bcd[7:4];
   assign ones   = instr.bit_bcd[3:0];
   assign bit_ok = (ones <= MAX_BCD_DIGIT) &&
                   ((tens == 4'h0) || ((tens == 4'h1) && (ones <= MAX_BIT_ONES_HI)));

   assign oref.point_class = instr.point_class;
   assign oref.indirect    = instr.indirect;
   assign oref.index       = index;
   assign oref.bit_num     = tens[0] ? 4'(ones + BIT_TENS_WEIGHT) : ones;

endmodule : operand_decoder

// >>> rtl/bool_stack.sv
// boolean rung stack with push, top update and two-level merge
`timescale 1ns/1ns
module bool_stack
   import contact_eval_pkg::*;
#(
   parameter int unsigned LEVELS  = STACK_LEVELS,
   parameter int unsigned DEPTH_W = $clog2(LEVELS + 1)
)(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst_b,
   // stack command
   input  wire stack_op_type        op,
   input  wire logic                value,
   // stack state
   output logic [LEVELS-1:0]        levels,
   output logic [DEPTH_W-1:0]       depth,
   output logic                     full
);

   logic [LEVELS-1:0]  lvl_q;
   logic [LEVELS-1:0]  lvl_d;
   logic [LEVELS-1:0]  pushed;
   logic [LEVELS-1:0]  popped;
   logic [DEPTH_W-1:0] depth_q;
   logic [DEPTH_W-1:0] depth_d;
   logic               merged;

   // ---------------------------------------------------------------
   // shifted images: a push moves every level down one place
   // ---------------------------------------------------------------
   for (genvar i = 0; i < LEVELS; i++) begin : g_level
      if (i == 0) begin : g_top
         assign pushed[i] = value;
      end else begin : g_deep
         assign pushed[i] = lvl_q[i-1];
      end
      if (i == LEVELS - 1) begin : g_bottom
         assign popped[i] = 1'b0;
      end else begin : g_upper
         assign popped[i] = lvl_q[i+1];
      end
   end

   assign merged = (op == stk_merge_and) ? (lvl_q[0] & lvl_q[1])
                                         : (lvl_q[0] | lvl_q[1]);

   always_comb begin
      lvl_d   = lvl_q;
      depth_d = depth_q;
      case (op)
         stk_clear: begin
            lvl_d   = '0;
            depth_d = '0;
         end
         stk_push: begin
            lvl_d   = pushed;
            depth_d = DEPTH_W'(depth_q + 1'b1);
         end
         stk_set_top: begin
            lvl_d[0] = value;
         end
         stk_merge_and, stk_merge_or: begin
            lvl_d    = {popped[LEVELS-1:1], merged};
            depth_d  = DEPTH_W'(depth_q - 1'b1);
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lvl_q   <= '0;
         depth_q <= '0;
      end else begin
         lvl_q   <= lvl_d;
         depth_q <= depth_d;
      end
   end

   assign levels = lvl_q;
   assign depth  = depth_q;
   assign full   = (depth_q == DEPTH_W'(LEVELS));

endmodule : bool_stack

// >>> rtl/boolean_contact_evaluator.sv
// boolean contact evaluator: executes contact, merge and coil instructions
//
// Function
// - push open contact: stack gets point state
// - push closed contact: stack gets complement
// - push word bit: stack gets selected bit
// - push inverted word bit: complement of bit
// - parallel open: top ORed with point
// - parallel closed: top ORed with complement
// - parallel word bit: top ORed with bit
// - parallel inverted bit: top ORed with complement
// - series open: top ANDed with point
// - series closed: top ANDed with complement
// - series word bit: top ANDed with bit
// - point index ranges checked per class
// - word operand bit number 0 to 15
// - eight-level stack, push shifts levels down
// - merges combine top two by AND/OR
// - more than eight levels rejects rung
// - coil copies rung value to target
`timescale 1ns/1ns
module boolean_contact_evaluator
   import contact_eval_pkg::*;
#(
   parameter int unsigned LEVELS  = STACK_LEVELS,
   parameter int unsigned DEPTH_W = $clog2(LEVELS + 1)
)(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst_b,
   // instruction stream
   input  wire logic                instr_valid,
   input  wire instr_type           instr,
   output logic                     instr_ready,
   // operand access
   output logic                     mem_rd_en,
   output logic                     mem_wr_en,
   output operand_ref_type          mem_ref,
   output logic                     mem_wr_value,
   input  wire logic                mem_rd_point,
   input  wire logic [15:0]         mem_rd_word,
   // status
   output logic                     rung_value,
   output logic [DEPTH_W-1:0]       stack_depth,
   output logic                     rung_error,
   output logic [LEVELS-1:0]        stack_levels
);

   typedef enum logic {st_idle, st_exec} state_type;

   state_type        state_q;
   state_type        state_d;
   opcode_type       op_q;
   opcode_type       op_d;
   operand_ref_type  ref_q;
   operand_ref_type  ref_d;
   logic             index_ok_q;
   logic             index_ok_d;
   logic             bit_ok_q;
   logic             bit_ok_d;
   logic             err_q;
   logic             err_d;

   operand_ref_type  dec_ref;
   logic             dec_index_ok;
   logic             dec_bit_ok;
   logic             accept;

   logic             is_push;
   logic             is_par;
   logic             is_ser;
   logic             is_word;
   logic             is_inv;
   logic             is_coil;
   logic             is_merge;
   logic             uses_operand;
   logic             operand_ok;
   logic             fault;
   logic             raw_bit;
   logic             contact;
   logic             active;
   stack_op_type     stk_op;
   logic             stk_value;
   logic             full;

   // ---------------------------------------------------------------
   // operand decode happens at accept so the references come from flops
   // ---------------------------------------------------------------
   operand_decoder u_decoder (
      .instr    (instr),
      .oref     (dec_ref),
      .index_ok (dec_index_ok),
      .bit_ok   (dec_bit_ok)
   );

   bool_stack #(
      .LEVELS  (LEVELS),
      .DEPTH_W (DEPTH_W)
   ) u_stack (
      .clock  (clock),
      .rst_b  (rst_b),
      .op     (stk_op),
      .value  (stk_value),
      .levels (stack_levels),
      .depth  (stack_depth),
      .full   (full)
   );

   assign instr_ready = (state_q == st_idle);
   assign accept      = instr_valid && instr_ready;

   // ---------------------------------------------------------------
   // opcode classification
   // ---------------------------------------------------------------
   always_comb begin
      is_push  = 1'b0;
      is_par   = 1'b0;
      is_ser   = 1'b0;
      is_word  = 1'b0;
      is_inv   = 1'b0;
      is_coil  = 1'b0;
      is_merge = 1'b0;
      case (op_q)
         op_push_open_contact:          is_push = 1'b1;
         op_push_closed_contact:        {is_push, is_inv} = 2'h3;
         op_push_word_bit:              {is_push, is_word} = 2'h3;
         op_push_inverted_word_bit:     {is_push, is_word, is_inv} = 3'h7;
         op_parallel_open_contact:      is_par = 1'b1;
         op_parallel_closed_contact:    {is_par, is_inv} = 2'h3;
         op_parallel_word_bit:          {is_par, is_word} = 2'h3;
         op_parallel_inverted_word_bit: {is_par, is_word, is_inv} = 3'h7;
         op_series_open_contact:        is_ser = 1'b1;
         op_series_closed_contact:      {is_ser, is_inv} = 2'h3;
         op_series_word_bit:            {is_ser, is_word} = 2'h3;
         op_series_inverted_word_bit:   {is_ser, is_word, is_inv} = 3'h7;
         op_merge_series_levels,
         op_merge_parallel_levels:      is_merge = 1'b1;
         op_coil_write:                 is_coil = 1'b1;
         op_coil_word_bit:              {is_coil, is_word} = 2'h3;
         default: begin
         end
      endcase
   end

   assign uses_operand = is_push || is_par || is_ser || is_coil;
   // point contacts take plain indices; word bits need a word and a legal bit
   assign operand_ok = is_word ? ((ref_q.point_class == cls_word_memory) && index_ok_q
                                  && bit_ok_q)
                               : ((ref_q.point_class != cls_word_memory) && !ref_q.indirect
                                  && index_ok_q);

   assign fault = (uses_operand && !operand_ok)
               || (is_push && full)
               || ((is_par || is_ser || is_coil) && (stack_depth == '0))
               || (is_merge && (stack_depth < DEPTH_W'(2)));

   assign active  = (state_q == st_exec) && !err_q;
   assign raw_bit = is_word ? mem_rd_word[ref_q.bit_num] : mem_rd_point;
   assign contact = raw_bit ^ is_inv;

   // ---------------------------------------------------------------
   // stack command; a faulted rung stays frozen until the next rung start
   // ---------------------------------------------------------------
   always_comb begin
      stk_op    = stk_hold;
      stk_value = contact;
      if ((state_q == st_exec) && (op_q == op_rung_start)) begin
         stk_op = stk_clear;
      end else if (active && !fault) begin
         if (is_push) begin
            stk_op = stk_push;
         end else if (is_par) begin
            stk_op    = stk_set_top;
            stk_value = stack_levels[0] | contact;
         end else if (is_ser) begin
            stk_op    = stk_set_top;
            stk_value = stack_levels[0] & contact;
         end else if (op_q == op_merge_series_levels) begin
            stk_op = stk_merge_and;
         end else if (op_q == op_merge_parallel_levels) begin
            stk_op = stk_merge_or;
         end
      end
   end

   // ---------------------------------------------------------------
   // operand access; a coil writes the top level and does not pop it
   // ---------------------------------------------------------------
   assign mem_ref      = ref_q;
   assign mem_rd_en    = active && !fault && (is_push || is_par || is_ser);
   assign mem_wr_en    = active && !fault && is_coil;
   assign mem_wr_value = stack_levels[0];
   assign rung_value   = stack_levels[0];
   assign rung_error   = err_q;

   // ---------------------------------------------------------------
   // sequencing: one instruction takes two cycles
   // ---------------------------------------------------------------
   always_comb begin
      state_d    = state_q;
      op_d       = op_q;
      ref_d      = ref_q;
      index_ok_d = index_ok_q;
      bit_ok_d   = bit_ok_q;
      err_d      = err_q;
      if (accept) begin
         state_d    = st_exec;
         op_d       = instr.opcode;
         ref_d      = dec_ref;
         index_ok_d = dec_index_ok;
         bit_ok_d   = dec_bit_ok;
      end else if (state_q == st_exec) begin
         state_d = st_idle;
         if (op_q == op_rung_start) begin
            err_d = 1'b0;
         end else if (active && fault) begin
            err_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= st_idle;
         op_q       <= op_no_operation;
         ref_q      <= '0;
         index_ok_q <= 1'b0;
         bit_ok_q   <= 1'b0;
         err_q      <= 1'b0;
      end else begin
         state_q    <= state_d;
         op_q       <= op_d;
         ref_q      <= ref_d;
         index_ok_q <= index_ok_d;
         bit_ok_q   <= bit_ok_d;
         err_q      <= err_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence s_do(opcode_type o);
      (state_q == st_exec) && !err_q && !fault && (op_q == o);
   endsequence

   sequence s_taken;
      instr_valid && instr_ready;
   endsequence

   chk_push_open_point: assert property (s_do(op_push_open_contact) |=>
      rung_value == $past(mem_rd_point) && stack_depth == $past(stack_depth) + 1)
      else $error("open contact push wrong");
   chk_push_closed_point: assert property (s_do(op_push_closed_contact) |=>
      rung_value == !$past(mem_rd_point)) else $error("closed contact push wrong");
   chk_push_word_bit: assert property (s_do(op_push_word_bit) |=>
      rung_value == $past(mem_rd_word[ref_q.bit_num])) else $error("word bit push wrong");
   chk_push_inv_bit: assert property (s_do(op_push_inverted_word_bit) |=>
      rung_value == !$past(mem_rd_word[ref_q.bit_num])) else $error("inverted push wrong");
   chk_par_open_or: assert property (s_do(op_parallel_open_contact) |=>
      rung_value == ($past(rung_value) | $past(mem_rd_point))) else $error("parallel open wrong");
   chk_par_closed_or: assert property (s_do(op_parallel_closed_contact) |=>
      rung_value == ($past(rung_value) | !$past(mem_rd_point)))
      else $error("parallel closed wrong");
   chk_par_bit_or: assert property (s_do(op_parallel_word_bit) |=>
      rung_value == ($past(rung_value) | $past(mem_rd_word[ref_q.bit_num])))
      else $error("parallel bit wrong");
   chk_par_inv_or: assert property (s_do(op_parallel_inverted_word_bit) |=>
      rung_value == ($past(rung_value) | !$past(mem_rd_word[ref_q.bit_num])))
      else $error("parallel inverted bit wrong");
   chk_ser_open_and: assert property (s_do(op_series_open_contact) |=>
      rung_value == ($past(rung_value) & $past(mem_rd_point))) else $error("series open wrong");
   chk_ser_closed_and: assert property (s_do(op_series_closed_contact) |=>
      rung_value == ($past(rung_value) & !$past(mem_rd_point)))
      else $error("series closed wrong");
   chk_ser_bit_and: assert property (s_do(op_series_word_bit) |=>
      rung_value == ($past(rung_value) & $past(mem_rd_word[ref_q.bit_num])))
      else $error("series bit wrong");
   chk_point_range: assert property ((state_q == st_exec) && !err_q && !is_word
      && is_push && !index_ok_q |=> rung_error) else $error("bad index not rejected");
   chk_bit_range: assert property (s_taken ##0 (instr.bit_bcd[7:4] > 4'h1)
      |=> !bit_ok_q) else $error("bit number above 15 accepted");
   chk_octal_digit: assert property (s_taken ##0 instr.index_bcd[3]
      |=> !index_ok_q) else $error("digit 8 or 9 accepted");
   chk_push_shift: assert property (s_do(op_push_open_contact) |=>
      stack_levels[LEVELS-1:1] == $past(stack_levels[LEVELS-2:0])) else $error("push no shift");
   chk_merge_and: assert property (s_do(op_merge_series_levels) |=>
      rung_value == $past(stack_levels[0] & stack_levels[1])
      && stack_depth == $past(stack_depth) - 1) else $error("series merge wrong");
   chk_overflow_reject: assert property ((state_q == st_exec) && !err_q && is_push
      && full |=> rung_error && stack_levels == $past(stack_levels) [*2])
      else $error("ninth level not rejected");
   chk_coil_copy: assert property (s_do(op_coil_write) |->
      mem_wr_en && mem_wr_value == stack_levels[0] ##1 !mem_wr_en) else $error("coil wrong");
   chk_deep_kept: assert property ((state_q == st_exec) && (is_par || is_ser)
      |=> stack_levels[LEVELS-1:1] == $past(stack_levels[LEVELS-1:1]))
      else $error("deep level changed");

endmodule : boolean_contact_evaluator

// >>> verification/boolean_contact_evaluator_tb.sv
// self-checking testbench of the boolean contact evaluator
`timescale 1ns/1ns
module boolean_contact_evaluator_tb;
   import contact_eval_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic            clock, rst_b, instr_valid, instr_ready, mem_rd_en, mem_wr_en;
   logic            mem_wr_value, mem_rd_point, rung_value, rung_error;
   instr_type       instr;
   operand_ref_type mem_ref, ref_seen;
   logic [15:0]     mem_rd_word;
   logic [3:0]      stack_depth;
   logic [7:0]      stack_levels;
   logic            rd_seen, wr_seen, wv_seen;
   int              n_mismatch, n_checks, cycles;

   boolean_contact_evaluator #(.LEVELS(8), .DEPTH_W(4)) dut (
      .clock(clock), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
      .mem_ref(mem_ref), .mem_wr_value(mem_wr_value), .mem_rd_point(mem_rd_point),
      .mem_rd_word(mem_rd_word), .rung_value(rung_value), .stack_depth(stack_depth),
      .rung_error(rung_error), .stack_levels(stack_levels));

   // ---------------------------------------------------------------
   // shared drivers
   // ---------------------------------------------------------------
   task automatic results;
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // operand lines are inverted after the exec cycle so a stale value never passes
   task automatic do_op(input opcode_type o, input point_class_type c, input logic [15:0] idx,
                        input logic [7:0] b, input logic p, input logic [15:0] w,
                        input logic ind = 1'b0);
      int n;
      @(posedge clock);
      instr_valid  <= 1'b1;
      instr        <= '{o, c, ind, idx, b};
      mem_rd_point <= p;
      mem_rd_word  <= w;
      // ready is judged mid-cycle where it has settled; the next rising edge takes the op
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (instr_ready !== 1'b1 && n < 20);
      if (instr_ready !== 1'b1) n_mismatch++;
      @(posedge clock);
      instr_valid <= 1'b0;
      @(negedge clock);
      rd_seen  = mem_rd_en;
      wr_seen  = mem_wr_en;
      wv_seen  = mem_wr_value;
      ref_seen = mem_ref;
      @(posedge clock);
      mem_rd_point <= ~p;
      mem_rd_word  <= ~w;
      @(negedge clock);
   endtask : do_op

   task automatic start_rung;
      do_op(op_rung_start, cls_input, 16'h0000, 8'h00, 1'b0, 16'h0000);
   endtask : start_rung

   task automatic push(input logic v);
      do_op(op_push_open_contact, cls_input, 16'h0001, 8'h00, v, 16'h0000);
   endtask : push

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_push;
      start_rung();
      do_op(op_push_open_contact, cls_input, 16'h0377, 8'h00, 1'b1, 16'h0000);
      `CHK(ref_seen.index, 12'h0FF)
      `CHK(rd_seen, 1'b1)
      do_op(op_push_closed_contact, cls_input, 16'h0002, 8'h00, 1'b1, 16'h0000);
      `CHK(rung_value, 1'b0)
      do_op(op_push_word_bit, cls_word_memory, 16'h1400, 8'h12, 1'b0, 16'h1000);
      `CHK(ref_seen.bit_num, 4'hC)
      `CHK(rung_value, 1'b1)
      do_op(op_push_inverted_word_bit, cls_word_memory, 16'h1400, 8'h15, 1'b0, 16'h8000);
      `CHK(stack_levels, 8'h0A)
      `CHK(stack_depth, 4'h4)
   endtask : t_push

   task automatic t_combine;
      opcode_type ops [8];
      logic [2:0] k;
      logic       a, v, exp;
      ops = '{op_parallel_open_contact, op_parallel_closed_contact, op_parallel_word_bit,
              op_parallel_inverted_word_bit, op_series_open_contact, op_series_closed_contact,
              op_series_word_bit, op_series_inverted_word_bit};
      for (int i = 0; i < 32; i++) begin
         k = i[4:2];
         a = i[1];
         v = i[0];
         exp = k[2] ? (a & (v ^ k[0])) : (a | (v ^ k[0]));
         start_rung();
         push(1'b1);
         push(a);
         if (k[1]) do_op(ops[k], cls_word_memory, 16'h1400, 8'h07, 1'b0, {8'h00, v, 7'h00});
         else do_op(ops[k], cls_control_relay, 16'h0777, 8'h00, v, 16'h0000);
         `CHK(rung_value, exp)
         `CHK(stack_levels, {6'h00, 1'b1, exp})
         `CHK(stack_depth, 4'h2)
      end
   endtask : t_combine

   task automatic t_merge;
      start_rung();
      push(1'b1);
      push(1'b1);
      push(1'b0);
      do_op(op_merge_series_levels, cls_input, 16'h0000, 8'h00, 1'b1, 16'hFFFF);
      `CHK({stack_depth, stack_levels}, {4'h2, 8'h02})
      do_op(op_merge_parallel_levels, cls_input, 16'h0000, 8'h00, 1'b0, 16'h0000);
      `CHK({stack_depth, stack_levels}, {4'h1, 8'h01})
      do_op(op_no_operation, cls_input, 16'h0000, 8'h00, 1'b1, 16'hFFFF);
      `CHK({rd_seen, stack_depth, stack_levels}, {1'b0, 4'h1, 8'h01})
   endtask : t_merge

   task automatic t_overflow;
      start_rung();
      for (int i = 0; i < 8; i++) push(i[0]);
      `CHK({rung_error, stack_depth, stack_levels}, {1'b0, 4'h8, 8'h55})
      push(1'b0);
      `CHK({rung_error, rd_seen, stack_levels}, {1'b1, 1'b0, 8'h55})
      push(1'b1);
      `CHK({rung_error, rd_seen, stack_depth}, {1'b1, 1'b0, 4'h8})
      start_rung();
      `CHK({rung_error, stack_depth}, {1'b0, 4'h0})
   endtask : t_overflow

   task automatic t_coil;
      start_rung();
      do_op(op_push_closed_contact, cls_input, 16'h0003, 8'h00, 1'b0, 16'h0000);
      do_op(op_coil_write, cls_output, 16'h0005, 8'h00, 1'b0, 16'h0000);
      `CHK({wr_seen, wv_seen, rd_seen, ref_seen.index}, {3'b110, 12'h005})
      push(1'b0);
      do_op(op_coil_write, cls_output, 16'h0005, 8'h00, 1'b1, 16'h0000);
      `CHK({wr_seen, wv_seen, stack_depth}, {2'b10, 4'h2})
      do_op(op_coil_word_bit, cls_word_memory, 16'h1400, 8'h11, 1'b1, 16'h0000);
      `CHK({wr_seen, wv_seen, ref_seen.bit_num}, {2'b10, 4'hB})
   endtask : t_coil

   task automatic rng(input opcode_type o, input point_class_type c, input logic [15:0] idx,
                      input logic [7:0] b, input logic err, input logic ind = 1'b0);
      start_rung();
      do_op(o, c, idx, b, 1'b1, 16'hFFFF, ind);
      `CHK({rung_error, rd_seen}, {err, ~err})
   endtask : rng

   task automatic t_ranges;
      rng(op_push_open_contact, cls_input, 16'h0377, 8'h00, 1'b0);
      rng(op_push_open_contact, cls_stage, 16'h0400, 8'h00, 1'b1);
      rng(op_push_open_contact, cls_control_relay, 16'h0777, 8'h00, 1'b0);
      rng(op_push_open_contact, cls_system_flag_bit, 16'h1000, 8'h00, 1'b1);
      rng(op_push_open_contact, cls_timer_done, 16'h0177, 8'h00, 1'b0);
      rng(op_push_open_contact, cls_count_done_bit, 16'h0200, 8'h00, 1'b1);
      rng(op_push_open_contact, cls_output, 16'h0018, 8'h00, 1'b1);
      rng(op_push_word_bit, cls_word_memory, 16'h1400, 8'h15, 1'b0);
      rng(op_push_word_bit, cls_word_memory, 16'h1400, 8'h16, 1'b1);
      rng(op_push_word_bit, cls_input, 16'h0001, 8'h01, 1'b1);
      rng(op_push_word_bit, cls_word_memory, 16'h1400, 8'h20, 1'b1);
      // a pointer is legal for a word bit, never for a point contact
      rng(op_push_word_bit, cls_word_memory, 16'h1400, 8'h03, 1'b0, 1'b1);
      `CHK(ref_seen.indirect, 1'b1)
      rng(op_push_open_contact, cls_input, 16'h0001, 8'h00, 1'b1, 1'b1);
   endtask : t_ranges

   // ---------------------------------------------------------------
   // clock, reset, sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      rst_b        = 1'b0;
      instr_valid  = 1'b0;
      instr        = '{op_no_operation, cls_input, 1'b0, 16'h0000, 8'h00};
      mem_rd_point = 1'b0;
      mem_rd_word  = 16'h0000;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      t_push();
      t_combine();
      t_merge();
      t_overflow();
      t_coil();
      t_ranges();
      results();
   end
endmodule : boolean_contact_evaluator_tb
